// >>> rtl/fsr_read.sv
// Serial flash read-command sequencer: command, address, dummy and data phases
//
// Summary of operation
// - Select low, opcode 03h, bits sampled rising edge
// - Data MSB first, changes on falling edge
// - Pointer advances per byte, streams while clocked
// - Select high stops driving, ends command
// - Reads while busy are discarded entirely
// - Address 24 or 32 bits by mode
// - 13h always 32-bit address, unlike 03h
// - 03h only in standard SPI mode
// - 13h/0Ch/3Ch/6Ch only standard SPI mode
// - 0Bh waits eight dummy clocks
// - 0Ch is 0Bh with 32-bit address
// - 3Bh eight dummies, two bits per clock
// - 3Ch is 3Bh with 32-bit address
// - 6Bh four lanes, needs quad enable
// - Quad read eight dummies, host releases lanes
// - 6Ch is 6Bh with 32-bit address
// - BBh address and data on two lanes
// - BBh four clocks after address carry the mode bits
// - Three-byte mode uses extended address byte
`timescale 1ns/1ps
module fsr_read #(
  parameter int AW = 16
) (
  input  wire logic          clock_in,
  input  wire logic          rst_n_in,
  input  wire logic          chip_sel_n_in,
  input  wire logic          serial_clk_in,
  input  wire logic [3:0]    io_lane_in,
  output logic      [3:0]    io_lane_out,
  output logic      [3:0]    io_lane_oe_n_out,
  input  wire logic          busy_in,
  input  wire logic          std_spi_mode_in,
  input  wire logic          quad_enable_bit_in,
  input  wire logic          four_byte_mode_in,
  input  wire logic [7:0]    ext_addr_in,
  input  wire logic          load_en_in,
  input  wire logic [AW-1:0] load_addr_in,
  input  wire logic [7:0]    load_data_in,
  output logic               read_active_out,
  output logic               cmd_ignored_out,
  output logic      [7:0]    continuation_mode_bits_out
);

  // ******************************************************************
  // Array store
  // ******************************************************************
  fsr_mem_if #(.AW(AW)) mem_bus ();

  fsr_mem #(.AW(AW)) u_mem (
    .clock_in (clock_in),
    .mem      (mem_bus.store)
  );

  typedef enum logic [2:0] {
    FSR_IDLE, FSR_CMD, FSR_ADDR, FSR_MODE, FSR_DUMMY, FSR_DATA, FSR_IGNORE
  } fsr_state_t;

  // ******************************************************************
  // State
  // ******************************************************************
  fsr_state_t   st_q,    st_d;
  logic         sclk_q;
  logic [7:0]   op_q,    op_d;
  logic [31:0]  addr_q,  addr_d;
  logic [5:0]   cnt_q,   cnt_d;
  logic [5:0]   dummy_q, dummy_d;
  logic [2:0]   lanes_q, lanes_d;
  logic         dio_q,   dio_d;
  logic         wide_q,  wide_d;
  logic [7:0]   sh_q,    sh_d;
  logic [3:0]   bcnt_q,  bcnt_d;
  logic [3:0]   out_q,   out_d;
  logic [3:0]   oe_n_q,  oe_n_d;
  logic [7:0]   mode_q,  mode_d;
  logic         ign_q,   ign_d;

  logic         rise;
  logic         fall;
  logic [7:0]   op_full;
  fsr_pkg::fsr_cmd_t dec;
  logic [31:0]  addr_shift;
  logic [7:0]   lane_byte;

  // Pins are taken as synchronous, so edges come from one registered copy
  assign rise = serial_clk_in & ~sclk_q;
  assign fall = ~serial_clk_in & sclk_q;

  assign op_full = {op_q[6:0], io_lane_in[0]};
  assign dec     = fsr_pkg::fsr_decode(op_full);

  always_comb begin
    addr_shift = dio_q ? {addr_q[29:0], io_lane_in[1], io_lane_in[0]}
                       : {addr_q[30:0], io_lane_in[0]};
    lane_byte = mem_bus.rd_data;
  end

  assign mem_bus.rd_addr = addr_q[AW-1:0];
  assign mem_bus.wr_en   = load_en_in;
  assign mem_bus.wr_addr = load_addr_in;
  assign mem_bus.wr_data = load_data_in;

  // ******************************************************************
  // Sequencer next state
  // ******************************************************************
  always_comb begin
    logic [7:0] byte_v;
    byte_v  = 8'h00;
    st_d    = st_q;
    op_d    = op_q;
    addr_d  = addr_q;
    cnt_d   = cnt_q;
    dummy_d = dummy_q;
    lanes_d = lanes_q;
    dio_d   = dio_q;
    wide_d  = wide_q;
    sh_d    = sh_q;
    bcnt_d  = bcnt_q;
    out_d   = out_q;
    oe_n_d  = oe_n_q;
    mode_d  = mode_q;
    ign_d   = ign_q;
    if (chip_sel_n_in) begin
      // Deselect aborts any phase and releases every lane
      st_d   = FSR_IDLE;
      oe_n_d = fsr_pkg::LANES_OFF_N;
      dio_d  = 1'b0;
      ign_d  = 1'b0;
    end else begin
      case (st_q)
        FSR_IDLE: begin
          st_d   = FSR_CMD;
          cnt_d  = fsr_pkg::CMD_BITS;
          op_d   = 8'h00;
          oe_n_d = fsr_pkg::LANES_OFF_N;
        end
        FSR_CMD: begin
          if (rise) begin
            op_d  = op_full;
            cnt_d = cnt_q - 6'd1;
            if (cnt_q == 6'd1) begin
              // Busy, wrong protocol mode or missing quad enable all discard the read
              if (dec.known && !busy_in && std_spi_mode_in
                  && (!dec.quad_req || quad_enable_bit_in)) begin
                st_d    = FSR_ADDR;
                wide_d  = dec.force4 | four_byte_mode_in;
                dummy_d = dec.dummy;
                lanes_d = dec.lanes;
                dio_d   = dec.dual_io;
                addr_d  = fsr_pkg::ADDR_RST;
                if (dec.force4 | four_byte_mode_in) begin
                  cnt_d = dec.dual_io ? (fsr_pkg::ADDR_BITS_4B >> 1) : fsr_pkg::ADDR_BITS_4B;
                end else begin
                  cnt_d = dec.dual_io ? (fsr_pkg::ADDR_BITS_3B >> 1) : fsr_pkg::ADDR_BITS_3B;
                end
              end else begin
                st_d  = FSR_IGNORE;
                ign_d = 1'b1;
              end
            end
          end
        end
        FSR_ADDR: begin
          if (rise) begin
            addr_d = addr_shift;
            cnt_d  = cnt_q - 6'd1;
            if (cnt_q == 6'd1) begin
              if (!wide_q) begin
                addr_d = {ext_addr_in, addr_shift[23:0]};
              end
              bcnt_d = 4'd0;
              if (dio_q) begin
                st_d   = FSR_MODE;
                cnt_d  = dummy_q;
                mode_d = fsr_pkg::MODE_RST;
              end else if (dummy_q != 6'd0) begin
                st_d  = FSR_DUMMY;
                cnt_d = dummy_q;
              end else begin
                st_d = FSR_DATA;
              end
            end
          end
        end
        FSR_MODE: begin
          // Mode bits ride in the four clocks ahead of dual I/O data
          if (rise) begin
            mode_d = {mode_q[5:0], io_lane_in[1], io_lane_in[0]};
            cnt_d  = cnt_q - 6'd1;
            if (cnt_q == 6'd1) begin
              st_d = FSR_DATA;
            end
          end
        end
        FSR_DUMMY: begin
          // Input lanes are not looked at here
          if (rise) begin
            cnt_d = cnt_q - 6'd1;
            if (cnt_q == 6'd1) begin
              st_d = FSR_DATA;
            end
          end
        end
        FSR_DATA: begin
          if (fall) begin
            if (bcnt_q == 4'd0) begin
              byte_v = lane_byte;
              addr_d = addr_q + 32'd1;
              bcnt_d = 4'(fsr_pkg::BYTE_BITS / 6'(lanes_q)) - 4'd1;
            end else begin
              byte_v = sh_q;
              bcnt_d = bcnt_q - 4'd1;
            end
            sh_d = byte_v << lanes_q;
            case (lanes_q)
              3'd4: begin
                out_d  = byte_v[7:4];
                oe_n_d = 4'h0;
              end
              3'd2: begin
                out_d  = {2'b00, byte_v[7], byte_v[6]};
                oe_n_d = 4'hC;
              end
              default: begin
                out_d  = {2'b00, byte_v[7], 1'b0};
                oe_n_d = 4'hD;
              end
            endcase
          end
        end
        FSR_IGNORE: begin
          oe_n_d = fsr_pkg::LANES_OFF_N;
        end
        default: begin
          st_d = FSR_IDLE;
        end
      endcase
    end
  end

  // ******************************************************************
  // Registers
  // ******************************************************************
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      st_q    <= FSR_IDLE;
      sclk_q  <= 1'b0;
      op_q    <= 8'h00;
      addr_q  <= fsr_pkg::ADDR_RST;
      cnt_q   <= 6'd0;
      dummy_q <= 6'd0;
      lanes_q <= 3'd1;
      dio_q   <= 1'b0;
      wide_q  <= 1'b0;
      sh_q    <= 8'h00;
      bcnt_q  <= 4'd0;
      out_q   <= fsr_pkg::LANES_RST;
      oe_n_q  <= fsr_pkg::LANES_OFF_N;
      mode_q  <= fsr_pkg::MODE_RST;
      ign_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      sclk_q  <= serial_clk_in;
      op_q    <= op_d;
      addr_q  <= addr_d;
      cnt_q   <= cnt_d;
      dummy_q <= dummy_d;
      lanes_q <= lanes_d;
      dio_q   <= dio_d;
      wide_q  <= wide_d;
      sh_q    <= sh_d;
      bcnt_q  <= bcnt_d;
      out_q   <= out_d;
      oe_n_q  <= oe_n_d;
      mode_q  <= mode_d;
      ign_q   <= ign_d;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  logic active_q;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      active_q <= 1'b0;
    end else begin
      active_q <= (st_d == FSR_ADDR) || (st_d == FSR_MODE) ||
                  (st_d == FSR_DUMMY) || (st_d == FSR_DATA);
    end
  end

  assign io_lane_out                = out_q;
  assign io_lane_oe_n_out           = oe_n_q;
  assign read_active_out            = active_q;
  assign cmd_ignored_out            = ign_q;
  assign continuation_mode_bits_out = mode_q;

endmodule : fsr_read

// >>> rtl/fsr_pkg.sv
// Constants and types shared by the serial flash read-command block
package fsr_pkg;

  // ******************************************************************
  // Command codes
  // ******************************************************************
  localparam logic [7:0] OP_READ     = 8'h03;
  localparam logic [7:0] OP_READ4    = 8'h13;
  localparam logic [7:0] OP_FAST     = 8'h0B;
  localparam logic [7:0] OP_FAST4    = 8'h0C;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_DUAL4    = 8'h3C;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OP_QUAD4    = 8'h6C;
  localparam logic [7:0] OP_DUAL_IO  = 8'hBB;

  // ******************************************************************
  // Phase lengths and reset values
  // ******************************************************************
  localparam logic [5:0] CMD_BITS       = 6'h08;
  localparam logic [5:0] ADDR_BITS_3B   = 6'h18;
  localparam logic [5:0] ADDR_BITS_4B   = 6'h20;
  localparam logic [5:0] DUMMY_FAST     = 6'h08;
  localparam logic [5:0] DUMMY_DUAL_IO  = 6'h04;
  localparam logic [5:0] BYTE_BITS      = 6'h08;
  localparam logic [3:0] LANES_OFF_N    = 4'hF;
  localparam logic [3:0] LANES_RST      = 4'h0;
  localparam logic [7:0] MODE_RST       = 8'h00;
  localparam logic [31:0] ADDR_RST      = 32'h0000_0000;

  // ******************************************************************
  // Decoded command attributes
  // ******************************************************************
  typedef struct packed {
    logic       known;
    logic       force4;
    logic       quad_req;
    logic       dual_io;
    logic [5:0] dummy;
    logic [2:0] lanes;
  } fsr_cmd_t;

  function automatic fsr_cmd_t fsr_decode(input logic [7:0] op);
    fsr_cmd_t c;
    c = '{known: 1'b1, force4: 1'b0, quad_req: 1'b0, dual_io: 1'b0,
          dummy: 6'h00, lanes: 3'd1};
    case (op)
      OP_READ:     c.force4 = 1'b0;
      OP_READ4:    c.force4 = 1'b1;
      OP_FAST:     c.dummy = DUMMY_FAST;
      OP_FAST4:    begin c.dummy = DUMMY_FAST; c.force4 = 1'b1; end
      OP_DUAL_OUT: begin c.dummy = DUMMY_FAST; c.lanes = 3'd2; end
      OP_DUAL4:    begin c.dummy = DUMMY_FAST; c.lanes = 3'd2; c.force4 = 1'b1; end
      OP_QUAD_OUT: begin c.dummy = DUMMY_FAST; c.lanes = 3'd4; c.quad_req = 1'b1; end
      OP_QUAD4:    begin
        c.dummy = DUMMY_FAST; c.lanes = 3'd4; c.quad_req = 1'b1; c.force4 = 1'b1;
      end
      OP_DUAL_IO:  begin c.dummy = DUMMY_DUAL_IO; c.lanes = 3'd2; c.dual_io = 1'b1; end
      default:     c.known = 1'b0;
    endcase
    return c;
  endfunction : fsr_decode

endpackage : fsr_pkg

// >>> rtl/fsr_mem_if.sv
// Interface between the read sequencer and its array store
`timescale 1ns/1ps
interface fsr_mem_if #(parameter int AW = 16);
  logic [AW-1:0] rd_addr;
  logic [7:0]    rd_data;
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0]    wr_data;
  modport ctrl  (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
  modport store (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface : fsr_mem_if

// >>> rtl/fsr_mem.sv
// Byte-wide array store with registered read data
`timescale 1ns/1ps
module fsr_mem #(
  parameter int AW = 16
) (
  input  wire logic clock_in,
  fsr_mem_if.store  mem
);
  logic [7:0] array_q [2**AW];
  logic [7:0] rd_q;

  always_ff @(posedge clock_in) begin
    if (mem.wr_en) begin
      array_q[mem.wr_addr] <= mem.wr_data;
    end
    rd_q <= array_q[mem.rd_addr];
  end

  assign mem.rd_data = rd_q;
endmodule : fsr_mem

// >>> tb/fsr_read_chk.sv
// Port-level checker for the read-command sequencer
`timescale 1ns/1ps
module fsr_read_chk (
  input wire logic       clock_in,
  input wire logic       rst_n_in,
  input wire logic       chip_sel_n_in,
  input wire logic       serial_clk_in,
  input wire logic       busy_in,
  input wire logic       std_spi_mode_in,
  input wire logic       quad_enable_bit_in,
  input wire logic [3:0] io_lane_out,
  input wire logic [3:0] io_lane_oe_n_out,
  input wire logic       read_active_out,
  input wire logic       cmd_ignored_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  property p_oe_idle;
    chip_sel_n_in [*3] |-> io_lane_oe_n_out == 4'hF;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("lanes driven when deselected");
  property p_act_idle;
    chip_sel_n_in [*3] |-> !read_active_out;
  endproperty
  a_act_idle: assert property (p_act_idle) else $error("read still active");
  property p_oe_set;
    io_lane_oe_n_out inside {4'hF, 4'hD, 4'hC, 4'h0};
  endproperty
  a_oe_set: assert property (p_oe_set) else $error("odd lane enable set");
  property p_quad;
    io_lane_oe_n_out == 4'h0 |-> quad_enable_bit_in;
  endproperty
  a_quad: assert property (p_quad) else $error("quad lanes without enable");
  property p_std;
    $rose(read_active_out) |-> $past(std_spi_mode_in);
  endproperty
  a_std: assert property (p_std) else $error("read taken outside standard mode");
  property p_busy;
    $rose(read_active_out) |-> !$past(busy_in);
  endproperty
  a_busy: assert property (p_busy) else $error("read taken while busy");
  property p_ign_off;
    cmd_ignored_out |-> io_lane_oe_n_out == 4'hF && !read_active_out;
  endproperty
  a_ign_off: assert property (p_ign_off) else $error("refused read drives lanes");
  property p_ign_hold;
    cmd_ignored_out && !chip_sel_n_in |=> cmd_ignored_out;
  endproperty
  a_ign_hold: assert property (p_ign_hold) else $error("refusal dropped early");
  property p_oe_on;
    $past(io_lane_oe_n_out) == 4'hF && io_lane_oe_n_out != 4'hF
      |-> !$past(serial_clk_in) && ($past(serial_clk_in, 2) || $past(serial_clk_in, 3));
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("drive began off a falling edge");
  property p_out_fall;
    $changed(io_lane_out) && !$past(chip_sel_n_in) && $past(io_lane_oe_n_out) != 4'hF
      |-> !$past(serial_clk_in) && ($past(serial_clk_in, 2) || $past(serial_clk_in, 3));
  endproperty
  a_out_fall: assert property (p_out_fall) else $error("data moved off a falling edge");
endmodule : fsr_read_chk

bind fsr_read fsr_read_chk u_chk (
  .clock_in, .rst_n_in, .chip_sel_n_in, .serial_clk_in, .busy_in, .std_spi_mode_in,
  .quad_enable_bit_in, .io_lane_out, .io_lane_oe_n_out, .read_active_out, .cmd_ignored_out
);

// >>> tb/fsr_host.sv
// Host controller model: select, serial clock and lane drive
`timescale 1ns/1ps
module fsr_host (
  input  wire logic       clock_in,
  input  wire logic [3:0] dev_lane_in,
  input  wire logic [3:0] dev_oe_n_in,
  output logic            chip_sel_n_out,
  output logic            serial_clk_out,
  output logic      [3:0] lane_out
);
  logic [3:0] drv = 4'h0;
  logic [3:0] en = 4'h0;
  logic [3:0] junk_q = 4'h5;
  int         lo = 3;

  initial begin
    chip_sel_n_out = 1'b1;
    serial_clk_out = 1'b0;
  end
  // Floating lanes toggle so a stale value never reads as data
  always @(posedge clock_in) junk_q <= ~junk_q;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_out[i] = en[i] ? drv[i] : (!dev_oe_n_in[i] ? dev_lane_in[i] : junk_q[i]);
    end
  end

  task automatic w(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : w
  task automatic select();
    chip_sel_n_out = 1'b0;
    w(2);
  endtask : select
  // One serial clock: fall, low phase, sample, rise, high phase
  task automatic clk1(input logic [3:0] d, input logic [3:0] e, output logic [3:0] g);
    serial_clk_out = 1'b0;
    drv = d;
    en = e;
    w(lo);
    g = lane_out;
    serial_clk_out = 1'b1;
    w(2);
  endtask : clk1
  task automatic deselect();
    serial_clk_out = 1'b0;
    en = 4'h0;
    w(2);
    chip_sel_n_out = 1'b1;
    w(3);
  endtask : deselect
endmodule : fsr_host

// >>> tb/serial_flash_read_commands_bench.sv
// Self-checking bench for the read-command sequencer
`timescale 1ns/1ps
module serial_flash_read_commands_bench;
  logic       clock_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       busy_in = 1'b0;
  logic       std_spi_mode_in = 1'b1;
  logic       quad_enable_bit_in = 1'b1;
  logic       four_byte_mode_in = 1'b0;
  logic       load_en_in = 1'b0;
  logic [7:0] ext_addr_in = 8'h5A;
  logic [7:0] load_data_in = 8'h00;
  logic [8:0] load_addr_in = 9'h000;
  logic       chip_sel_n_in, serial_clk_in, read_active_out, cmd_ignored_out;
  logic [3:0] io_lane_in, io_lane_out, io_lane_oe_n_out;
  logic [7:0] continuation_mode_bits_out;
  logic [7:0] exp_mem [512];
  logic [7:0] ops [9] = '{8'h03, 8'h13, 8'h0B, 8'h0C, 8'h3B, 8'h3C, 8'h6B, 8'h6C, 8'hBB};
  int         n_errors = 0;
  int         n_checks = 0;

  always #2 clock_in = ~clock_in;

  fsr_read #(.AW(9)) dut (
    .clock_in, .rst_n_in, .chip_sel_n_in, .serial_clk_in, .io_lane_in, .io_lane_out,
    .io_lane_oe_n_out, .busy_in, .std_spi_mode_in, .quad_enable_bit_in, .four_byte_mode_in,
    .ext_addr_in, .load_en_in, .load_addr_in, .load_data_in, .read_active_out,
    .cmd_ignored_out, .continuation_mode_bits_out
  );
  fsr_host host (
    .clock_in, .dev_lane_in(io_lane_out), .dev_oe_n_in(io_lane_oe_n_out),
    .chip_sel_n_out(chip_sel_n_in), .serial_clk_out(serial_clk_in), .lane_out(io_lane_in)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic summarize();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic run(input logic [7:0] op, input logic fb, input logic ok,
                     input logic [31:0] a, input int nb);
    int          aw;
    int          ln;
    logic [3:0]  g;
    logic [7:0]  b;
    logic [31:0] x;
    aw = (op == 8'h13 || op[3:0] == 4'hC || fb) ? 32 : 24;
    ln = (op[7:4] == 4'h3 || op == 8'hBB) ? 2 : (op[7:4] == 4'h6) ? 4 : 1;
    four_byte_mode_in = fb;
    host.select();
    for (int i = 7; i >= 0; i--) host.clk1({3'b000, op[i]}, 4'h1, g);
    if (!ok) begin
      repeat (8) host.clk1(4'h0, 4'h1, g);
      chk(cmd_ignored_out, 1);
      chk({read_active_out, io_lane_oe_n_out}, 5'h0F);
    end else begin
      if (op == 8'hBB) begin
        for (int i = aw - 1; i > 0; i -= 2) host.clk1({2'b00, a[i -: 2]}, 4'h3, g);
        b = 8'hF5;
        for (int i = 7; i > 0; i -= 2) host.clk1({2'b00, b[i -: 2]}, 4'h3, g);
        // Lanes let go in the high phase, a full cycle ahead of the first data fall
        host.en = 4'h0;
        host.w(1);
      end else begin
        for (int i = aw - 1; i >= 0; i--) host.clk1({3'b000, a[i]}, 4'h1, g);
        repeat ((op == 8'h03 || op == 8'h13) ? 0 : 8) host.clk1(4'h0, 4'h0, g);
      end
      chk({read_active_out, io_lane_oe_n_out}, 5'h1F);
      for (int k = 0; k < nb; k++) begin
        b = 8'h00;
        for (int j = 0; j < 8 / ln; j++) begin
          host.clk1(4'h0, 4'h0, g);
          if (ln == 1) b = {b[6:0], g[1]};
          else if (ln == 2) b = {b[5:0], g[1:0]};
          else b = {b[3:0], g};
        end
        x = a + 32'(k);
        chk(b, exp_mem[x[8:0]]);
      end
      if (op == 8'hBB) chk(continuation_mode_bits_out, 8'hF5);
    end
    host.deselect();
    chk({read_active_out, io_lane_oe_n_out}, 5'h0F);
  endtask : run

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    host.w(16);
    rst_n_in = 1'b1;
    for (int i = 0; i < 512; i++) begin
      exp_mem[i] = 8'(i * 37 + 11);
      load_en_in = 1'b1;
      load_addr_in = 9'(i);
      load_data_in = exp_mem[i];
      host.w(1);
    end
    load_en_in = 1'b0;
    for (int f = 0; f < 2; f++) begin
      for (int i = 0; i < 9; i++) run(ops[i], f[0], 1'b1, 32'h3C00_01FC + 32'(i), 3);
    end
    busy_in = 1'b1;
    run(8'h03, 1'b0, 1'b0, 32'h0000_0010, 1);
    busy_in = 1'b0;
    std_spi_mode_in = 1'b0;
    for (int i = 0; i < 9; i++) run(ops[i], 1'b0, 1'b0, 32'h0000_0000, 1);
    std_spi_mode_in = 1'b1;
    quad_enable_bit_in = 1'b0;
    run(8'h6B, 1'b0, 1'b0, 32'h0000_0000, 1);
    run(8'h6C, 1'b1, 1'b0, 32'h0000_0000, 1);
    quad_enable_bit_in = 1'b1;
    run(8'hA5, 1'b0, 1'b0, 32'h0000_0000, 1);
    host.lo = 6;
    run(8'h3B, 1'b0, 1'b1, 32'h0000_0100, 2);
    summarize();
  end

  // Hang guard
  initial begin
    host.w(100000);
    n_errors++;
    summarize();
  end
endmodule : serial_flash_read_commands_bench
